// ==== motor_fault_status_control_regs.sv ====
// Controller fault status, system status and device control registers.
`timescale 1ns/1ps

// How it works
// - Bit 31 is OR of fault flags.
// - Bit 29 flags position detect frequency fault.
// - Bits 28, 27 flag position timing faults.
// - Bit 26 shows bus current limit active.
// - Bit 25 flags resistance/inductance measurement error.
// - Bit 24 flags back-EMF measurement error.
// - Bits 23, 22 flag abnormal lock conditions.
// - Bit 21 flags absent motor.
// - Bit 20 set when any lock triggers.
// - Bits 19, 18 flag current lock limits.
// - Bits 17, 16 flag supply under/over voltage.
// - Bits 15, 14 flag loop saturation.
// - Control word sits at offset EAh.
// - Status words sit at E4h, E6h, E8h.
// - Bits 31/30 store or reload non-volatile configuration.
// - Bits 29/28 clear faults, retry counter.
// - Bits 19:11 give alignment angle modulo 360.
// - Host tickles bit 10; device clears it.
module motor_fault_status_control_regs
  import motor_regs_pkg::*;
(
  // Clock and reset from the device core.
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Host access and live inputs from the same clock domain.
  input  wire reg_req_s    req,
  input  wire fault_in_s   faults,
  input  wire logic [31:0] sys_status_a,
  input  wire logic [31:0] motor_params,
  input  wire logic [31:0] meas_status,
  input  wire logic        nvm_busy,
  // Read answer and control outputs, all registered.
  output logic [31:0]      rdata,
  output logic             rvalid,
  output logic             nvm_store_request,
  output logic             nvm_load_request,
  output logic             fault_clear_strobe,
  output logic             retry_counter_clear,
  output logic [8:0]       align_angle,
  output logic             tickle_pulse
);

  // Current and next state.
  state_s s_q;
  state_s s_d;

  // True when an address names a register of this block.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == FAULT_FLAGS_OFS) || (a == SYS_STATUS_A_OFS) ||
             (a == MOTOR_PARAM_OFS) || (a == MEAS_STATUS_OFS) ||
             (a == DEV_CTRL_OFS);
  endfunction : mapped

  // Fold a 9-bit angle into 0..359; one subtraction covers 360..511.
  function automatic logic [8:0] wrap_angle(input logic [8:0] a);
    wrap_angle = (a >= ANGLE_FULL) ? 9'(a - ANGLE_FULL) : a;
  endfunction : wrap_angle

  // Fault word as seen by the host, rebuilt each cycle from live events.
  logic [31:0] fault_live;
  logic        any_lock;
  logic        ctl_write;
  logic [31:0] ctrl_view;

  // Gather raw flags into their bit positions.
  always_comb begin
    fault_live = 32'h0000_0000;
    any_lock = faults.abnormal_speed_lock | faults.abnormal_backemf_lock |
               faults.motor_absent_fault | faults.current_lock_limit_fault |
               faults.hard_current_lock_limit_fault;
    fault_live[FLT_POS_FREQ_BIT]  = faults.position_detect_freq_error;
    fault_live[FLT_POS_T1_BIT]    = faults.position_detect_timing1_error;
    fault_live[FLT_POS_T2_BIT]    = faults.position_detect_timing2_error;
    fault_live[FLT_BUS_ILIM_BIT]  = faults.bus_current_limit_active;
    fault_live[FLT_MEAS_RL_BIT]   = faults.param_meas_rl_error;
    fault_live[FLT_MEAS_BEMF_BIT] = faults.param_meas_backemf_error;
    fault_live[FLT_ABN_SPD_BIT]   = faults.abnormal_speed_lock;
    fault_live[FLT_ABNORMAL_BACKEMF_LOCK_BIT]  = faults.abnormal_backemf_lock;
    fault_live[FLT_NO_MOTOR_BIT]  = faults.motor_absent_fault;
    fault_live[FLT_ANY_LOCK_BIT]  = any_lock;
    fault_live[FLT_LOCK_LIM_BIT]  = faults.current_lock_limit_fault;
    fault_live[FLT_HW_LOCK_BIT]   = faults.hard_current_lock_limit_fault;
    fault_live[FLT_SUP_LOW_BIT]   = faults.supply_low_fault;
    fault_live[FLT_SUP_HIGH_BIT]  = faults.supply_high_fault;
    fault_live[FLT_SPD_SAT_BIT]   = faults.speed_loop_saturated;
    fault_live[FLT_CUR_SAT_BIT]   = faults.current_loop_saturated;
    // The host timeout fault sits alone below the reserved field.
    fault_live[FLT_WDOG_BIT]      = faults.host_timeout_fault;
    fault_live[FLT_SUMMARY_BIT]   = |fault_live[30:0];
  end

  // Write-only fields of the control word read back as zero.
  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[CTL_NVM_STORE_BIT] = s_q.nvm_store_q;
    ctrl_view[CTL_NVM_LOAD_BIT]  = s_q.nvm_load_q;
    ctrl_view[CTL_TICKLE_BIT]    = s_q.tickle_q;
    // Angle and clear fields are write-only, so they read as zero.
  end

  assign ctl_write = req.wr && (req.addr == DEV_CTRL_OFS);

  // Next-state logic for the whole block.
  always_comb begin
    // Every field holds unless a branch below says otherwise.
    s_d = s_q;
    // Strobes last one cycle unless written again.
    s_d.fault_clear_strobe_q  = 1'b0;
    s_d.retry_counter_clear_q = 1'b0;
    s_d.tickle_pulse_q        = 1'b0;
    s_d.rvalid_q              = 1'b0;
    // Fault flags mirror the detectors; they stay latched in the core.
    // Reads use the live word, so the host never sees a stale flag.
    s_d.fault_q = fault_live;
    // requests drop once storage is idle again
    if (!nvm_busy) begin
      s_d.nvm_store_q = 1'b0;
      s_d.nvm_load_q  = 1'b0;
    end
    // device clears tickle after one cycle
    if (s_q.tickle_q) begin
      s_d.tickle_q = 1'b0;
    end
    // Writes come last, so a set in the same cycle beats a clear.
    if (ctl_write) begin
      if (req.wdata[CTL_NVM_STORE_BIT]) begin
        s_d.nvm_store_q = 1'b1;
      end
      if (req.wdata[CTL_NVM_LOAD_BIT]) begin
        s_d.nvm_load_q = 1'b1;
      end
      s_d.fault_clear_strobe_q  = req.wdata[CTL_FLT_CLR_BIT];
      s_d.retry_counter_clear_q = req.wdata[CTL_RETRY_CLR_BIT];
      // angle field stored raw, applied folded
      s_d.angle_q     = req.wdata[CTL_ANGLE_HI:CTL_ANGLE_LO];
      s_d.angle_mod_q = wrap_angle(req.wdata[CTL_ANGLE_HI:CTL_ANGLE_LO]);
      if (req.wdata[CTL_TICKLE_BIT]) begin
        s_d.tickle_q       = 1'b1;
        s_d.tickle_pulse_q = 1'b1;
      end
    end
    // Read path; unmapped offsets answer zero.
    if (req.rd) begin
      s_d.rvalid_q = 1'b1;
      case (req.addr)
        FAULT_FLAGS_OFS:  s_d.rdata_q = fault_live;
        SYS_STATUS_A_OFS: s_d.rdata_q = sys_status_a;
        MOTOR_PARAM_OFS:  s_d.rdata_q = motor_params;
        MEAS_STATUS_OFS:  s_d.rdata_q = meas_status;
        DEV_CTRL_OFS:     s_d.rdata_q = ctrl_view;
        default:          s_d.rdata_q = 32'h0000_0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops.
  // Nothing is decoded on the way out, so outputs carry no glitches.
  assign rdata               = s_q.rdata_q;
  assign rvalid              = s_q.rvalid_q;
  assign nvm_store_request   = s_q.nvm_store_q;
  assign nvm_load_request    = s_q.nvm_load_q;
  assign fault_clear_strobe  = s_q.fault_clear_strobe_q;
  assign retry_counter_clear = s_q.retry_counter_clear_q;
  assign align_angle         = s_q.angle_mod_q;
  assign tickle_pulse        = s_q.tickle_pulse_q;

  // Helper for the checks: a read of the fault word is taken this edge.
  logic fault_read;
  assign fault_read = req.rd && (req.addr == FAULT_FLAGS_OFS);

  // Checks beside the logic; every one watches what this block drives.
  // summary follows flags
  summary_or_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) fault_read |=> rdata[31] == (|rdata[30:0]))
    else $error("summary bit disagrees with flags");
  pos_freq_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) fault_read |=>
      rdata[29] == $past(faults.position_detect_freq_error))
    else $error("frequency fault bit wrong");
  pos_timing_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) fault_read |=>
      rdata[28:27] == {$past(faults.position_detect_timing1_error),
                       $past(faults.position_detect_timing2_error)})
    else $error("timing fault bits wrong");
  ilim_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    s_q.fault_q[26] == $past(faults.bus_current_limit_active))
    else $error("current limit bit wrong");
  meas_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    s_q.fault_q[25:24] == {$past(faults.param_meas_rl_error),
                           $past(faults.param_meas_backemf_error)})
    else $error("measurement bits wrong");
  abn_lock_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) fault_read |=>
      rdata[23:22] == {$past(faults.abnormal_speed_lock),
                       $past(faults.abnormal_backemf_lock)})
    else $error("abnormal lock bits wrong");
  no_motor_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) fault_read |=>
      rdata[21] == $past(faults.motor_absent_fault))
    else $error("motor absent bit wrong");
  lock_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) s_q.fault_q[20] ==
      (|{s_q.fault_q[23:21], s_q.fault_q[19:18]}))
    else $error("lock bits wrong");
  lock_limit_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) fault_read |=>
      rdata[19:18] == {$past(faults.current_lock_limit_fault),
                       $past(faults.hard_current_lock_limit_fault)})
    else $error("current lock limit bits wrong");
  supply_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    s_q.fault_q[17:14] == {$past(faults.supply_low_fault),
      $past(faults.supply_high_fault), $past(faults.speed_loop_saturated),
      $past(faults.current_loop_saturated)})
    else $error("supply or loop bits wrong");
  loop_sat_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) fault_read |=>
      rdata[15:14] == {$past(faults.speed_loop_saturated),
                       $past(faults.current_loop_saturated)})
    else $error("loop saturation bits wrong");
  ctrl_offset_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) req.wr && req.addr != DEV_CTRL_OFS |=>
      !fault_clear_strobe && !retry_counter_clear && !tickle_pulse)
    else $error("write to other offset took effect");
  status_read_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) req.rd && req.addr == SYS_STATUS_A_OFS |=>
      rvalid && rdata == $past(sys_status_a))
    else $error("status word read wrong");
  store_req_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) ctl_write && req.wdata[CTL_NVM_STORE_BIT] |=>
      nvm_store_request)
    else $error("store request not raised");
  load_req_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) ctl_write && req.wdata[CTL_NVM_LOAD_BIT] |=>
      nvm_load_request)
    else $error("load request not raised");
  clear_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) ctl_write |=>
      fault_clear_strobe == $past(req.wdata[CTL_FLT_CLR_BIT]) &&
      retry_counter_clear == $past(req.wdata[CTL_RETRY_CLR_BIT]))
    else $error("fault clear strobe wrong");
  strobe_drop_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) !ctl_write |=>
      !fault_clear_strobe && !retry_counter_clear)
    else $error("clear strobe held too long");
  angle_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) ctl_write |=> align_angle < ANGLE_FULL &&
      align_angle == 9'($past(req.wdata[CTL_ANGLE_HI:CTL_ANGLE_LO]) %
                        ANGLE_FULL))
    else $error("alignment angle wrong");
  angle_store_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) align_angle == 9'(s_q.angle_q % ANGLE_FULL))
    else $error("stored and applied angle disagree");
  tickle_set_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) ctl_write && req.wdata[CTL_TICKLE_BIT] |=>
      tickle_pulse && s_q.tickle_q)
    else $error("tickle write not seen");
  tickle_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) s_q.tickle_q && !ctl_write |=> !s_q.tickle_q)
    else $error("tickle bit not self cleared");
  unmapped_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) req.rd && !mapped(req.addr) |=>
      rvalid && rdata == 32'h0000_0000)
    else $error("reserved offset read nonzero");
  reserved_ctl_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) req.rd && req.addr == DEV_CTRL_OFS |=>
      (rdata & 32'h3FFF_FBFF) == 32'h0000_0000)
    else $error("control word reserved bits nonzero");
  reserved_flt_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) fault_read |=>
      (rdata & 32'h4000_3FF7) == 32'h0000_0000)
    else $error("fault word reserved bits nonzero");
  // Main scenarios: storage transfers, tickle, faults, angle wrap.
  store_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    nvm_store_request ##[1:20] !nvm_store_request);
  load_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    nvm_load_request);
  tickle_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    tickle_pulse);
  fault_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    rvalid && rdata[31]);
  wrap_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    s_q.angle_q >= ANGLE_FULL);

endmodule : motor_fault_status_control_regs

// ==== motor_regs_pkg.sv ====
// Constants, field positions and carrier types for the motor status registers.
package motor_regs_pkg;

  // Register byte offsets in the volatile space.
  localparam logic [7:0] FAULT_FLAGS_OFS   = 8'hE2;
  localparam logic [7:0] SYS_STATUS_A_OFS  = 8'hE4;
  localparam logic [7:0] MOTOR_PARAM_OFS   = 8'hE6;
  localparam logic [7:0] MEAS_STATUS_OFS   = 8'hE8;
  localparam logic [7:0] DEV_CTRL_OFS      = 8'hEA;

  // Fault word field positions.
  localparam int FLT_SUMMARY_BIT   = 31;
  localparam int FLT_POS_FREQ_BIT  = 29;
  localparam int FLT_POS_T1_BIT    = 28;
  localparam int FLT_POS_T2_BIT    = 27;
  localparam int FLT_BUS_ILIM_BIT  = 26;
  localparam int FLT_MEAS_RL_BIT   = 25;
  localparam int FLT_MEAS_BEMF_BIT = 24;
  localparam int FLT_ABN_SPD_BIT   = 23;
  localparam int FLT_ABNORMAL_BACKEMF_LOCK_BIT  = 22;
  localparam int FLT_NO_MOTOR_BIT  = 21;
  localparam int FLT_ANY_LOCK_BIT  = 20;
  localparam int FLT_LOCK_LIM_BIT  = 19;
  localparam int FLT_HW_LOCK_BIT   = 18;
  localparam int FLT_SUP_LOW_BIT   = 17;
  localparam int FLT_SUP_HIGH_BIT  = 16;
  localparam int FLT_SPD_SAT_BIT   = 15;
  localparam int FLT_CUR_SAT_BIT   = 14;
  localparam int FLT_WDOG_BIT      = 3;

  // Control word field positions.
  localparam int CTL_NVM_STORE_BIT = 31;
  localparam int CTL_NVM_LOAD_BIT  = 30;
  localparam int CTL_FLT_CLR_BIT   = 29;
  localparam int CTL_RETRY_CLR_BIT = 28;
  localparam int CTL_ANGLE_HI      = 19;
  localparam int CTL_ANGLE_LO      = 11;
  localparam int CTL_TICKLE_BIT    = 10;

  // Reset values and the angle modulus.
  localparam logic [31:0] DEV_CTRL_RESET = 32'h0000_0000;
  localparam logic [8:0]  ANGLE_RESET    = 9'h000;
  localparam logic [8:0]  ANGLE_FULL     = 9'h168;

  // Raw fault events from the detection logic (levels).
  typedef struct packed {
    logic position_detect_freq_error;
    logic position_detect_timing1_error;
    logic position_detect_timing2_error;
    logic bus_current_limit_active;
    logic param_meas_rl_error;
    logic param_meas_backemf_error;
    logic abnormal_speed_lock;
    logic abnormal_backemf_lock;
    logic motor_absent_fault;
    logic current_lock_limit_fault;
    logic hard_current_lock_limit_fault;
    logic supply_low_fault;
    logic supply_high_fault;
    logic speed_loop_saturated;
    logic current_loop_saturated;
    logic host_timeout_fault;
  } fault_in_s;

  // Register access request.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  // Whole module state.
  typedef struct packed {
    logic [31:0] fault_q;
    logic        nvm_store_q;
    logic        nvm_load_q;
    logic [8:0]  angle_q;
    logic [8:0]  angle_mod_q;
    logic        tickle_q;
    logic        tickle_pulse_q;
    logic        fault_clear_strobe_q;
    logic        retry_counter_clear_q;
    logic [31:0] rdata_q;
    logic        rvalid_q;
  } state_s;

endpackage : motor_regs_pkg

// ==== nvm_model.sv ====
// Behavioural model of the storage core that serves transfer requests.
`timescale 1ns/1ps
module nvm_model
  import motor_regs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic store_req,
  input  wire logic load_req,
  output logic      busy,
  output int        stores,
  output int        loads
);
  // Remaining cycles of the transfer now running.
  logic [2:0] cnt_q;

  // The store is kept busy a few cycles so a request seen as a level
  // is still counted once, as a slow real memory would.
  assign busy = (cnt_q != 3'h0);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
      stores <= 0;
      loads <= 0;
    end else if (busy) begin
      cnt_q <= cnt_q - 3'h1;
    end else if (store_req || load_req) begin
      cnt_q <= 3'h4;
      stores <= stores + int'(store_req);
      loads <= loads + int'(load_req);
    end
  end
endmodule : nvm_model

// ==== tb_motor_fault_status_control_regs.sv ====
// Self-checking bench for the motor fault, status and control registers.
`timescale 1ns/1ps
module tb_motor_fault_status_control_regs
  import motor_regs_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  reg_req_s    req = '0;
  fault_in_s   faults = '0;
  logic [31:0] st_a = 32'h1234_5678;
  logic [31:0] st_b = 32'h9ABC_DEF0;
  logic [31:0] st_c = 32'h0F1E_2D3C;
  logic        busy;
  logic [31:0] rdata;
  logic        rvalid;
  logic        st_rq;
  logic        ld_rq;
  logic        fclr;
  logic        rclr;
  logic [8:0]  angle;
  logic        tickle;
  int          stores;
  int          loads;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  // Fault word bit of each detector input, in struct order.
  localparam int POS [16] = '{29, 28, 27, 26, 25, 24, 23, 22,
                              21, 19, 18, 17, 16, 15, 14, 3};

  motor_fault_status_control_regs DUT (
    .sys_clk(sys_clk), .nrst(nrst), .req(req), .faults(faults),
    .sys_status_a(st_a), .motor_params(st_b), .meas_status(st_c),
    .nvm_busy(busy), .rdata(rdata), .rvalid(rvalid),
    .nvm_store_request(st_rq), .nvm_load_request(ld_rq),
    .fault_clear_strobe(fclr), .retry_counter_clear(rclr),
    .align_angle(angle), .tickle_pulse(tickle));

  nvm_model nvm (.sys_clk(sys_clk), .nrst(nrst), .store_req(st_rq),
    .load_req(ld_rq), .busy(busy), .stores(stores), .loads(loads));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard; the whole run needs well under this many cycles.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One write cycle; returns just after the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
    #1;
  endtask : wr

  // One read cycle; data is checked in the single valid cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge sys_clk);
    req <= '0;
    #1;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", e, rdata);
  endtask : rd

  // Expected fault word with only detector i active.
  function automatic logic [31:0] fexp(input int i);
    logic [31:0] v;
    v = 32'h0;
    v[POS[i]] = 1'b1;
    v[31] = 1'b1;
    if (i >= 6 && i <= 10) v[20] = 1'b1;
    return v;
  endfunction : fexp

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(DEV_CTRL_OFS, DEV_CTRL_RESET);
    rd(FAULT_FLAGS_OFS, 32'h0);
    $display("Test reset done");
    // Each detector alone sets its own bit and the summary.
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      faults <= fault_in_s'(16'h8000 >> i);
      rd(FAULT_FLAGS_OFS, fexp(i));
    end
    @(posedge sys_clk);
    faults <= '0;
    rd(FAULT_FLAGS_OFS, 32'h0);
    $display("Test faults done");
    rd(SYS_STATUS_A_OFS, st_a);
    rd(MOTOR_PARAM_OFS, st_b);
    rd(MEAS_STATUS_OFS, st_c);
    rd(8'hEC, 32'h0);
    $display("Test status done");
    wr(DEV_CTRL_OFS, 32'h2000_0000);
    chk("fault_clear", 32'h1, {31'h0, fclr});
    wr(DEV_CTRL_OFS, 32'h1000_0000);
    chk("retry_clear", 32'h1, {31'h0, rclr});
    wr(DEV_CTRL_OFS, 32'h000F_FC00);
    chk("tickle", 32'h1, {31'h0, tickle});
    chk("angle_511", 32'h97, {23'h0, angle});
    rd(DEV_CTRL_OFS, 32'h0);
    wr(DEV_CTRL_OFS, 32'h000B_3800);
    chk("angle_359", 32'h167, {23'h0, angle});
    wr(DEV_CTRL_OFS, 32'h0FF0_03FF);
    chk("angle_0", 32'h0, {23'h0, angle});
    chk("no_strobe", 32'h0, {29'h0, fclr, rclr, tickle});
    wr(MEAS_STATUS_OFS, 32'hFFFF_FFFF);
    chk("ro_write", 32'h0, {28'h0, st_rq, fclr, rclr, tickle});
    chk("ro_angle", 32'h0, {23'h0, angle});
    rd(DEV_CTRL_OFS, 32'h0);
    $display("Test control done");
    wr(DEV_CTRL_OFS, 32'h8000_0000);
    chk("store_req", 32'h1, {31'h0, st_rq});
    repeat (8) @(posedge sys_clk);
    wr(DEV_CTRL_OFS, 32'h4000_0000);
    chk("load_req", 32'h1, {31'h0, ld_rq});
    repeat (8) @(posedge sys_clk);
    chk("stores", 32'h1, 32'(stores));
    chk("loads", 32'h1, 32'(loads));
    $display("Test storage done");
    complete_run();
  end
endmodule : tb_motor_fault_status_control_regs
